// ---- src/cla_top.sv ----
`timescale 1ns/100ps
`include "cla_regs.svh"
// What this block does
// - Channel A result above upper threshold sets status bit 1.
// - Channel A result below lower threshold sets status bit 0.
// - Limit flags are sticky and clear when the status register is read or on a soft or hard reset.
// - Lower compare value is the 12-bit field followed by four zero bits.
// - Upper compare value is the 12-bit field followed by four one bits.
// - Lower comparator alerts while result is below the lower compare value.
// - Upper comparator alerts while result is above the upper compare value.
// - Lower-limit register sits at index 4, read-write, resets to zero.
// - Upper-limit register sits at index 5, read-write, resets to 0x0FFF.
// - Bits 15 to 12 of every word carry the register select.
// - Channel B result above upper threshold sets sticky status bit 5.
// - Channel B result below lower threshold sets sticky status bit 4.
// - Soft-reset code 0x3C clears limit flags, thresholds unchanged.
// - Hard-reset code 0xFF returns every register to its default.
module cla_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire cla_pkg::cla_conv_s conv,
  output logic [3:0] cmpAlert,
  output logic irq,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic cla_mapped(input logic [7:0] a);
    cla_mapped = (a[7:6] == 2'h0) && (a[5:2] >= `CLA_IDX_SETUP) && (a[5:2] <= `CLA_IDX_IRQMSK);
  endfunction : cla_mapped

  function automatic logic cla_over(input logic [15:0] v, input logic [11:0] thr);
    cla_over = v > {thr, `CLA_HIGH_FILL};
  endfunction : cla_over

  function automatic logic cla_under(input logic [15:0] v, input logic [11:0] thr);
    cla_under = v < {thr, `CLA_LOW_FILL};
  endfunction : cla_under

  logic [11:0] lowThr;
  logic [11:0] highThr;
  logic sdoMode;
  cla_pkg::cla_flags_t flags;
  cla_pkg::cla_flags_t irqStatus;
  cla_pkg::cla_flags_t irqMask;
  cla_pkg::cla_rd_e rdState;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic awHeld;
  logic wHeld;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // ---------------------------------------------------------------
  // Comparators
  // ---------------------------------------------------------------
  wire overA = cla_over(conv.chanA, highThr);
  wire underA = cla_under(conv.chanA, lowThr);
  wire overB = cla_over(conv.chanB, highThr);
  wire underB = cla_under(conv.chanB, lowThr);
  wire [3:0] cmpNow = {overB, underB, overA, underA};
  wire cla_pkg::cla_flags_t evt =
    conv.valid ? {overB, underB, 2'h0, overA, underA} : 6'h00;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  wire wrFire = awHeld && wHeld && !bvalid;
  wire [3:0] wrIdx = awAddr[5:2];
  wire wrOk = cla_mapped(awAddr);
  wire wrSel = (wData[15:12] == wrIdx) && (wStrb[1:0] == 2'h3);
  wire wrEn = wrFire && wrOk && wrSel;
  wire wrSetup = wrEn && (wrIdx == `CLA_IDX_SETUP);
  wire hardRst = wrSetup && (wData[7:0] == `CLA_HARD_CODE);
  wire softRst = wrSetup && (wData[7:0] == `CLA_SOFT_CODE);
  wire wrLow = wrEn && (wrIdx == `CLA_IDX_LOW) && !hardRst;
  wire wrHigh = wrEn && (wrIdx == `CLA_IDX_HIGH) && !hardRst;
  wire wrMask = wrEn && (wrIdx == `CLA_IDX_IRQMSK);
  wire cla_pkg::cla_flags_t w1c = (wrEn && (wrIdx == `CLA_IDX_IRQST)) ? wData[5:0] : 6'h00;

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  wire rdFire = arvalid && arready;
  wire [3:0] rdIdx = araddr[5:2];
  wire rdOk = cla_mapped(araddr);
  wire rdFlags = rdFire && rdOk && (rdIdx == `CLA_IDX_FLAGS);
  wire [11:0] rdPayload =
    (rdIdx == `CLA_IDX_SETUP) ? {3'h0, sdoMode, 8'h00} :
    (rdIdx == `CLA_IDX_FLAGS) ? {6'h00, flags} :
    (rdIdx == `CLA_IDX_LOW) ? lowThr :
    (rdIdx == `CLA_IDX_HIGH) ? highThr :
    (rdIdx == `CLA_IDX_IRQST) ? {6'h00, irqStatus} :
    {6'h00, irqMask};
  wire [31:0] rdWord = rdOk ? {16'h0000, rdIdx, rdPayload} : 32'h00000000;

  // ---------------------------------------------------------------
  // Flag and interrupt next state
  // ---------------------------------------------------------------
  // A conversion landing in the same cycle as any clear still leaves its mark.
  wire flagClr = rdFlags || softRst || hardRst;
  wire cla_pkg::cla_flags_t next_flags = (flagClr ? 6'h00 : flags) | evt;
  wire cla_pkg::cla_flags_t next_irqStatus = ((hardRst ? 6'h00 : irqStatus) & ~w1c) | evt;

  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign arready = (rdState == cla_pkg::RD_IDLE);
  assign rvalid = (rdState == cla_pkg::RD_DATA);
  assign irq = |(irqStatus & irqMask);

  // ---------------------------------------------------------------
  // Bus slave state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awAddr <= awaddr;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wData <= wdata;
        wStrb <= wstrb;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid <= 1'b0;
      bresp <= `CLA_RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp <= wrOk ? `CLA_RESP_OKAY : `CLA_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdState <= cla_pkg::RD_IDLE;
      rdata <= 32'h00000000;
      rresp <= `CLA_RESP_OKAY;
    end else begin
      case (rdState)
        cla_pkg::RD_IDLE: begin
          if (arvalid) begin
            rdState <= cla_pkg::RD_DATA;
            rdata <= rdWord;
            rresp <= rdOk ? `CLA_RESP_OKAY : `CLA_RESP_SLVERR;
          end
        end
        cla_pkg::RD_DATA: begin
          if (rready) begin
            rdState <= cla_pkg::RD_IDLE;
          end
        end
        default: begin
          rdState <= cla_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowThr <= `CLA_LOW_RST;
      highThr <= `CLA_HIGH_RST;
      sdoMode <= 1'b0;
      irqMask <= 6'h00;
    end else if (hardRst) begin
      lowThr <= `CLA_LOW_RST;
      highThr <= `CLA_HIGH_RST;
      sdoMode <= 1'b0;
      irqMask <= 6'h00;
    end else begin
      if (wrLow) begin
        lowThr <= wData[11:0];
      end
      if (wrHigh) begin
        highThr <= wData[11:0];
      end
      if (wrSetup) begin
        sdoMode <= wData[`CLA_BIT_SDO];
      end
      if (wrMask) begin
        irqMask <= wData[5:0];
      end
    end
  end

  // The comparator outputs follow the latest conversion; the flags keep history.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= 6'h00;
      irqStatus <= 6'h00;
      cmpAlert <= 4'h0;
    end else begin
      flags <= next_flags;
      irqStatus <= next_irqStatus;
      if (conv.valid) begin
        cmpAlert <= cmpNow;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence hardSeq;
    hardRst;
  endsequence
  sequence softSeq;
    softRst && !conv.valid;
  endsequence

  over_a_flag_a: assert property (conv.valid && overA |=> flags[`CLA_BIT_A_OVER])
    else $error("channel A over flag not set");
  under_a_flag_a: assert property (conv.valid && underA |=> flags[`CLA_BIT_A_UNDER])
    else $error("channel A under flag not set");
  flag_hold_a: assert property (!flagClr && !conv.valid |=> $stable(flags))
    else $error("limit flags changed without cause");
  flag_read_clear_a: assert property (rdFlags && !conv.valid |=> flags == 6'h00)
    else $error("status read did not clear flags");
  low_fill_a: assert property (conv.valid && conv.chanA[15:4] == lowThr |=> !cmpAlert[0])
    else $error("lower compare fill bits wrong");
  high_fill_a: assert property (conv.valid && conv.chanB[15:4] == highThr |=> !cmpAlert[3])
    else $error("upper compare fill bits wrong");
  low_cmp_a: assert property (conv.valid && conv.chanB < {lowThr, 4'h0} |=> cmpAlert[2])
    else $error("lower comparator missed");
  high_cmp_a: assert property (conv.valid && conv.chanB > {highThr, 4'hF} |=> cmpAlert[3])
    else $error("upper comparator missed");
  hard_low_a: assert property (hardSeq |=> lowThr == `CLA_LOW_RST)
    else $error("lower limit not restored");
  hard_high_a: assert property (hardSeq |=> highThr == `CLA_HIGH_RST)
    else $error("upper limit not restored");
  read_select_a: assert property (rdFire && rdOk |=> rdata[15:12] == $past(rdIdx))
    else $error("readback select field wrong");
  over_b_flag_a: assert property (conv.valid && overB |=> flags[`CLA_BIT_B_OVER])
    else $error("channel B over flag not set");
  under_b_flag_a: assert property (conv.valid && underB |=> flags[`CLA_BIT_B_UNDER])
    else $error("channel B under flag not set");
  soft_keep_a: assert property (softSeq |=> flags == 6'h00 ##0 $stable(lowThr))
    else $error("soft reset misbehaved");
  hard_all_a: assert property (hardSeq ##0 !conv.valid |=>
    irqMask == 6'h00 && flags == 6'h00)
    else $error("hard reset left state");
  once_per_conv_a: assert property (!conv.valid && !hardRst |=> $stable(cmpAlert))
    else $error("comparator moved without conversion");
  write_resp_a: assert property (wrFire |=> bvalid)
    else $error("write response missing");
endmodule : cla_top

// ---- src/cla_regs.svh ----
`ifndef CLA_REGS_SVH
`define CLA_REGS_SVH
// ---------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ---------------------------------------------------------------
`define CLA_IDX_SETUP 4'h2
`define CLA_IDX_FLAGS 4'h3
`define CLA_IDX_LOW 4'h4
`define CLA_IDX_HIGH 4'h5
`define CLA_IDX_IRQST 4'h6
`define CLA_IDX_IRQMSK 4'h7
// ---------------------------------------------------------------
// Field positions and reset values.
// ---------------------------------------------------------------
`define CLA_BIT_A_UNDER 0
`define CLA_BIT_A_OVER 1
`define CLA_BIT_B_UNDER 4
`define CLA_BIT_B_OVER 5
`define CLA_BIT_SDO 8
`define CLA_LOW_RST 12'h000
`define CLA_HIGH_RST 12'hFFF
`define CLA_LOW_FILL 4'h0
`define CLA_HIGH_FILL 4'hF
`define CLA_SOFT_CODE 8'h3C
`define CLA_HARD_CODE 8'hFF
`define CLA_RESP_OKAY 2'h0
`define CLA_RESP_SLVERR 2'h2
`endif

// ---- src/cla_pkg.sv ----
package cla_pkg;
  typedef struct packed {
    logic valid;
    logic [15:0] chanA;
    logic [15:0] chanB;
  } cla_conv_s;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } cla_rd_e;
  typedef logic [5:0] cla_flags_t;
endpackage : cla_pkg

// ---- testbench/cla_host.sv ----
`timescale 1ns/100ps
// ------------------------------------------------------------
// Register bus master standing in for the host controller.
// ------------------------------------------------------------
module cla_host (
  input wire logic core_clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // The caller puts the select field in wdata[15:12].
  // Released payloads are inverted so that no stale value is read as valid.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask : rd
endmodule : cla_host

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`include "cla_regs.svh"
module tb_top;
  logic core_clk, rst_b, irq;
  cla_pkg::cla_conv_s conv;
  logic [3:0] cmpAlert, wstrb;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int errors;
  int checked;

  cla_top dut (.core_clk, .rst_b, .conv, .cmpAlert, .irq, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  cla_host host (.core_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready);

  // ------------------------------------------------------------
  // Shared tasks.
  // ------------------------------------------------------------
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [33:0] e);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk({r, d}, e);
  endtask : rdc

  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    host.wr(a, d, r);
    chk({32'h0, r}, {32'h0, e});
  endtask : wrc

  // Flags land one edge after the pulse, so three edges pass before any check.
  task automatic cnv(input logic [15:0] a, input logic [15:0] b);
    conv <= {1'b1, a, b};
    @(posedge core_clk);
    conv.valid <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : cnv

  task automatic complete_run;
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // Clock, watchdog and test sequence.
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (4000) @(posedge core_clk);
    errors++;
    complete_run();
  end

  initial begin
    rst_b = 1'b0;
    conv = '0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rdc(8'h10, 34'h000004000);
    rdc(8'h14, 34'h000005FFF);
    rdc(8'h0C, 34'h000003000);
    wrc(8'h10, 32'h00004100, `CLA_RESP_OKAY);
    wrc(8'h14, 32'h00005800, `CLA_RESP_OKAY);
    wrc(8'h10, 32'h00001123, `CLA_RESP_OKAY);
    rdc(8'h10, 34'h000004100);
    rdc(8'h14, 34'h000005800);
    // Results equal to the compare values sit on the fill bits exactly.
    cnv(16'h1000, 16'h800F);
    chk({30'h0, cmpAlert}, 34'h0);
    cnv(16'h0FFF, 16'h8010);
    chk({30'h0, cmpAlert}, 34'h9);
    cnv(16'h8010, 16'h0FFF);
    chk({30'h0, cmpAlert}, 34'h6);
    cnv(16'h2000, 16'h2000);
    chk({30'h0, cmpAlert}, 34'h0);
    rdc(8'h0C, 34'h000003033);
    rdc(8'h0C, 34'h000003000);
    chk({33'h0, irq}, 34'h0);
    rdc(8'h18, 34'h000006033);
    wrc(8'h1C, 32'h00007001, `CLA_RESP_OKAY);
    chk({33'h0, irq}, 34'h1);
    wrc(8'h18, 32'h00006001, `CLA_RESP_OKAY);
    chk({33'h0, irq}, 34'h0);
    rdc(8'h18, 34'h000006032);
    cnv(16'h0FFF, 16'h2000);
    wrc(8'h08, 32'h00002155, `CLA_RESP_OKAY);
    rdc(8'h08, 34'h000002100);
    rdc(8'h0C, 34'h000003001);
    cnv(16'h0FFF, 16'h2000);
    wrc(8'h08, 32'h0000213C, `CLA_RESP_OKAY);
    rdc(8'h0C, 34'h000003000);
    rdc(8'h10, 34'h000004100);
    chk({33'h0, irq}, 34'h1);
    wrc(8'h08, 32'h000020FF, `CLA_RESP_OKAY);
    rdc(8'h10, 34'h000004000);
    rdc(8'h14, 34'h000005FFF);
    rdc(8'h08, 34'h000002000);
    rdc(8'h1C, 34'h000007000);
    chk({33'h0, irq}, 34'h0);
    wrc(8'h40, 32'h00000000, `CLA_RESP_SLVERR);
    rdc(8'h40, 34'h200000000);
    complete_run();
  end
endmodule : tb_top
